// >>> core/switch_global_control_bank.sv
`timescale 1ns/1ps
module switch_global_control_bank
  import gctl_pkg::*;
#(
  parameter int FAST_CYC = FAST_PERIOD_CYC,
  parameter int SLOW_CYC = SLOW_PERIOD_CYC
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // management register port
  input  wire reg_req_s                    req,
  output logic [7:0]                       rdata,
  // storm policing
  input  wire storm_in_s                   storm_in,
  output logic [NUM_PORTS-1:0]             storm_drop,
  // priority lookup
  input  wire logic [2:0]                  pcp,
  output logic [PRIO_W-1:0]                pcp_prio,
  // unknown destination forwarding
  output logic [NUM_PORTS-1:0]             unk_fwd_mask,
  // host interface clock and pad control
  output host_clk_e                        host_clk_sel,
  output logic                             pad_drive_high
);

  localparam logic [TIMER_W-1:0] FAST_LAST = TIMER_W'(FAST_CYC - 1);
  localparam logic [TIMER_W-1:0] SLOW_LAST = TIMER_W'(SLOW_CYC - 1);

  gctl_state_s s_q;
  gctl_state_s s_d;

  logic [RATE_W-1:0] limit;
  logic              fast_tick;
  logic              slow_tick;

  function automatic logic [PRIO_W-1:0] prio_of(input logic [15:0] map, input logic [2:0] tag);
    prio_of = map[{tag, 1'b0} +: PRIO_W];
  endfunction

  function automatic logic [7:0] read_mux(input gctl_state_s s, input logic [7:0] addr);
    read_mux = 8'h00;
    unique case (addr)
      OFS_STORM_RATE_HIGH:   read_mux = {5'h00, s.rate_high};
      OFS_STORM_RATE_LOW:    read_mux = s.rate_low;
      OFS_FACTORY_TEST_A:    read_mux = VAL_FACTORY_TEST_A;
      OFS_FACTORY_TEST_B:    read_mux = VAL_FACTORY_TEST_B;
      OFS_FACTORY_TEST_C:    read_mux = VAL_FACTORY_TEST_C;
      OFS_HOST_CLOCK_SELECT: read_mux = {s.clk_sel, VAL_CLK_SEL_RSVD};
      OFS_PRIO_MAP_LOW:      read_mux = s.prio_map[7:0];
      OFS_PRIO_MAP_HIGH:     read_mux = s.prio_map[15:8];
      OFS_UNKNOWN_DEST:      read_mux = {s.unk_enable, s.pad_drive, s.unk_rsvd5, 1'b0,
                                         s.unk_rsvd3, s.unk_mask};
      default:               read_mux = 8'h00;
    endcase
  endfunction

  assign limit     = {s_q.rate_high, s_q.rate_low};
  assign fast_tick = (s_q.fast_cnt == FAST_LAST);
  assign slow_tick = (s_q.slow_cnt == SLOW_LAST);

  always_comb begin
    logic period_end;
    period_end = 1'b0;
    s_d = s_q;

    s_d.fast_cnt = fast_tick ? '0 : s_q.fast_cnt + TIMER_W'(1);
    s_d.slow_cnt = slow_tick ? '0 : s_q.slow_cnt + TIMER_W'(1);

    for (int p = 0; p < NUM_PORTS; p++) begin
      period_end = storm_in.fast_line_mode[p] ? fast_tick : slow_tick;
      if (period_end) begin
        s_d.blk_cnt[p] = storm_in.blk[p] && (limit != '0) ? RATE_W'(1) : '0;
      end else if (storm_in.blk[p] && (s_q.blk_cnt[p] < limit)) begin
        s_d.blk_cnt[p] = s_q.blk_cnt[p] + RATE_W'(1);
      end
    end

    if (req.rd) begin
      s_d.rdata = read_mux(s_q, req.addr);
    end

    if (req.wr) begin
      unique case (req.addr)
        OFS_STORM_RATE_HIGH: s_d.rate_high = req.wdata[RATE_HIGH_W-1:0];
        OFS_STORM_RATE_LOW:  s_d.rate_low  = req.wdata;
        // code 11 is reserved, write ignored
        OFS_HOST_CLOCK_SELECT: begin
          if (req.wdata[HCS_SEL_LSB +: 2] != HOST_CLK_RSVD) begin
            s_d.clk_sel = req.wdata[HCS_SEL_LSB +: 2];
          end
        end
        OFS_PRIO_MAP_LOW:    s_d.prio_map[7:0]  = req.wdata;
        OFS_PRIO_MAP_HIGH:   s_d.prio_map[15:8] = req.wdata;
        OFS_UNKNOWN_DEST: begin
          s_d.unk_enable = req.wdata[UNK_ENABLE_BIT];
          s_d.pad_drive  = req.wdata[UNK_PAD_BIT];
          s_d.unk_rsvd5  = req.wdata[UNK_RSVD5_BIT];
          s_d.unk_rsvd3  = req.wdata[UNK_RSVD3_BIT];
          s_d.unk_mask   = req.wdata[2:0];
        end
        // factory bytes and unmapped offsets ignore writes
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q.rate_high  <= RST_STORM_RATE_HIGH;
      s_q.rate_low   <= RST_STORM_RATE_LOW;
      s_q.clk_sel    <= RST_HOST_CLK_SEL;
      s_q.prio_map   <= RST_PRIO_MAP;
      s_q.unk_enable <= RST_UNK_ENABLE;
      s_q.pad_drive  <= RST_PAD_DRIVE;
      s_q.unk_rsvd5  <= RST_UNK_RSVD5;
      s_q.unk_rsvd3  <= RST_UNK_RSVD3;
      s_q.unk_mask   <= RST_UNK_PORT_MASK;
      s_q.fast_cnt   <= '0;
      s_q.slow_cnt   <= '0;
      s_q.blk_cnt    <= '0;
      s_q.rdata      <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata          = s_q.rdata;
  assign storm_drop     = {(s_q.blk_cnt[2] >= limit), (s_q.blk_cnt[1] >= limit), (s_q.blk_cnt[0] >= limit)};
  assign pcp_prio       = prio_of(s_q.prio_map, pcp);
  assign unk_fwd_mask   = s_q.unk_enable ? s_q.unk_mask : ALL_PORTS;
  assign host_clk_sel   = host_clk_e'(s_q.clk_sel);
  assign pad_drive_high = s_q.pad_drive;

endmodule

// >>> core/gctl_pkg.sv
package gctl_pkg;

  // register offsets on the management port
  localparam logic [7:0] OFS_STORM_RATE_HIGH   = 8'h06;
  localparam logic [7:0] OFS_STORM_RATE_LOW    = 8'h07;
  localparam logic [7:0] OFS_FACTORY_TEST_A    = 8'h08;
  localparam logic [7:0] OFS_FACTORY_TEST_B    = 8'h09;
  localparam logic [7:0] OFS_FACTORY_TEST_C    = 8'h0A;
  localparam logic [7:0] OFS_HOST_CLOCK_SELECT = 8'h0B;
  localparam logic [7:0] OFS_PRIO_MAP_LOW      = 8'h0C;
  localparam logic [7:0] OFS_PRIO_MAP_HIGH     = 8'h0D;
  localparam logic [7:0] OFS_UNKNOWN_DEST      = 8'h0E;

  // reset values and fixed contents
  localparam logic [2:0]  RST_STORM_RATE_HIGH = 3'h0;
  localparam logic [7:0]  RST_STORM_RATE_LOW  = 8'h63;
  localparam logic [7:0]  VAL_FACTORY_TEST_A  = 8'h00;
  localparam logic [7:0]  VAL_FACTORY_TEST_B  = 8'h24;
  localparam logic [7:0]  VAL_FACTORY_TEST_C  = 8'h35;
  localparam logic [5:0]  VAL_CLK_SEL_RSVD    = 6'h08;
  localparam logic [15:0] RST_PRIO_MAP        = 16'hFA50;
  localparam logic        RST_UNK_ENABLE      = 1'b0;
  localparam logic        RST_PAD_DRIVE       = 1'b1;
  localparam logic        RST_UNK_RSVD5       = 1'b0;
  localparam logic        RST_UNK_RSVD3       = 1'b0;
  localparam logic [2:0]  RST_UNK_PORT_MASK   = 3'h7;
  localparam logic [2:0]  ALL_PORTS           = 3'h7;

  // field positions, widths and port count
  localparam int HCS_SEL_LSB    = 6;
  localparam int UNK_ENABLE_BIT = 7;
  localparam int UNK_PAD_BIT    = 6;
  localparam int UNK_RSVD5_BIT  = 5;
  localparam int UNK_RSVD3_BIT  = 3;
  localparam int RATE_HIGH_W    = 3;
  localparam int RATE_W         = 11;
  localparam int NUM_PORTS      = 3;
  localparam int PRIO_W         = 2;

  typedef enum logic [1:0] {
    HOST_CLK_31M25 = 2'h0,
    HOST_CLK_62M5  = 2'h1,
    HOST_CLK_125M  = 2'h2
  } host_clk_e;
  localparam logic [1:0] RST_HOST_CLK_SEL = 2'h2;
  localparam logic [1:0] HOST_CLK_RSVD    = 2'h3;

  // timing
  localparam int CLK_KHZ        = 40000;
  localparam int FAST_PERIOD_MS = 67;
  localparam int SLOW_PERIOD_MS = 500;
  localparam int FAST_PERIOD_CYC = FAST_PERIOD_MS * CLK_KHZ;
  localparam int SLOW_PERIOD_CYC = SLOW_PERIOD_MS * CLK_KHZ;
  localparam int TIMER_W        = 25;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [NUM_PORTS-1:0] blk;
    logic [NUM_PORTS-1:0] fast_line_mode;
  } storm_in_s;

  typedef struct packed {
    logic [RATE_HIGH_W-1:0]                rate_high;
    logic [7:0]                            rate_low;
    logic [1:0]                            clk_sel;
    logic [15:0]                           prio_map;
    logic                                  unk_enable;
    logic                                  pad_drive;
    logic                                  unk_rsvd5;
    logic                                  unk_rsvd3;
    logic [2:0]                            unk_mask;
    logic [TIMER_W-1:0]                    fast_cnt;
    logic [TIMER_W-1:0]                    slow_cnt;
    logic [NUM_PORTS-1:0][RATE_W-1:0]      blk_cnt;
    logic [7:0]                            rdata;
  } gctl_state_s;

endpackage

// >>> tb/gctl_monitor.sv
`timescale 1ns/1ps
module gctl_monitor
  import gctl_pkg::*;
#(
  parameter int FAST_CYC = 40,
  parameter int SLOW_CYC = 100
) (
  // watched design ports
  input wire logic       clk,
  input wire logic       rst,
  input wire reg_req_s   req,
  input wire logic [7:0] rdata,
  input wire storm_in_s  storm_in,
  input wire logic [2:0] storm_drop,
  input wire logic [2:0] pcp,
  input wire logic [1:0] pcp_prio,
  input wire logic [2:0] unk_fwd_mask,
  input wire host_clk_e  host_clk_sel,
  input wire logic       pad_drive_high
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_FACT_B: assert property (req.rd && req.addr == OFS_FACTORY_TEST_B |=> rdata == 8'h24)
    else $error("factory byte b wrong");
  AST_FACT_C: assert property (req.rd && req.addr == OFS_FACTORY_TEST_C |=> rdata == 8'h35)
    else $error("factory byte c wrong");
  AST_CLK_RSVD: assert property (req.rd && req.addr == 8'h0B |=> rdata[5:0] == 6'h08)
    else $error("clock reserved bits wrong");
  AST_CLK_SEL: assert property (req.wr && req.addr == 8'h0B && req.wdata[7:6] != 2'h3
    |=> host_clk_sel == $past(req.wdata[7:6])) else $error("clock select not taken");
  AST_UNK: assert property (req.wr && req.addr == 8'h0E
    |=> unk_fwd_mask == ($past(req.wdata[7]) ? $past(req.wdata[2:0]) : 3'h7)) else $error("unknown mask wrong");
  // write effect lands one edge later
  AST_PRIO_HOLD: assert property ($past(!req.wr) && $stable(pcp) |-> $stable(pcp_prio))
    else $error("priority moved without cause");
  AST_RATE_LOW: assert property (req.wr && req.addr == 8'h07 ##1 req.rd && !req.wr && req.addr == 8'h07
    |=> rdata == $past(req.wdata, 2)) else $error("rate byte not stored");
  AST_DROP_CAUSE: assert property ($rose(storm_drop[0])
    |-> $past(storm_in.blk[0]) || $past(req.wr) || $past(req.wr, 2)) else $error("drop without block");
  COV_DROP: cover property ($rose(storm_drop[0]));
  COV_UNK: cover property (req.wr && req.addr == 8'h0E && req.wdata[7]);
  COV_CLK: cover property (req.wr && req.addr == 8'h0B && req.wdata[7:6] == 2'h3);
endmodule

bind switch_global_control_bank gctl_monitor #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC)) mon (.clk(clk),
  .rst(rst), .req(req), .rdata(rdata), .storm_in(storm_in), .storm_drop(storm_drop), .pcp(pcp),
  .pcp_prio(pcp_prio), .unk_fwd_mask(unk_fwd_mask), .host_clk_sel(host_clk_sel), .pad_drive_high(pad_drive_high));

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb
  import gctl_pkg::*;
;
  logic       clk = 0;
  logic       rst = 1;
  reg_req_s   req = '0;
  storm_in_s  sin = '0;
  logic [2:0] pcp = '0;
  logic [7:0] rdata;
  logic [2:0] drop, unk, prev;
  logic [1:0] prio;
  host_clk_e  hcs;
  logic       pad;
  int         n_errors = 0, checks_done = 0, cyc = 0;
  logic [7:0] rst_tab [11] = '{8'h00, 8'h00, 8'h63, 8'h00, 8'h24, 8'h35, 8'h88, 8'h50, 8'hFA, 8'h47, 8'h00};
  logic [7:0] ff_tab [11] = '{8'h00, 8'h07, 8'hFF, 8'h00, 8'h24, 8'h35, 8'h88, 8'hFF, 8'hFF, 8'hEF, 8'h00};

  switch_global_control_bank #(.FAST_CYC(40), .SLOW_CYC(100)) dut (.clk(clk), .rst(rst), .req(req),
    .rdata(rdata), .storm_in(sin), .storm_drop(drop), .pcp(pcp), .pcp_prio(prio), .unk_fwd_mask(unk),
    .host_clk_sel(hcs), .pad_drive_high(pad));

  initial forever #12.5 clk = ~clk;

  task automatic complete_run;
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // unknown-destination ports: restricted only while enabled
  function automatic logic [7:0] exp_unk(logic [7:0] u);
    exp_unk = u[UNK_ENABLE_BIT] ? {5'h00, u[2:0]} : {5'h00, ALL_PORTS};
  endfunction

  // strobe stays up so writes can run back to back
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk) req <= {2'b10, a, d};
  endtask

  task automatic idle;
    @(posedge clk) req <= '0;
    #1;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk) req <= {2'b01, a, 8'h00};
    idle();
    chk(rdata, e);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    int f0, f1;
    logic [15:0] m;
    logic [7:0] u;
    void'($urandom(32'hA1D5E7A1));
    repeat (5) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 11; i++) rd(8'(5 + i), rst_tab[i]);
    for (int t = 0; t < 8; t++) begin
      @(posedge clk) pcp <= 3'(t);
      #1 chk(prio, 8'(t / 2));
    end
    for (int i = 0; i < 11; i++) wr(8'(5 + i), 8'hFF);
    idle();
    for (int i = 0; i < 11; i++) rd(8'(5 + i), ff_tab[i]);
    for (int c = 0; c < 4; c++) begin
      wr(8'h0B, {2'(c), 6'h3F});
      rd(8'h0B, {(c == 3) ? 2'h2 : 2'(c), 6'h08});
      chk(hcs, (c == 3) ? 8'h02 : 8'(c));
    end
    wr(8'h0B, {HOST_CLK_31M25, VAL_CLK_SEL_RSVD});
    rd(8'h0B, 8'h08);
    chk(hcs, 8'h00);
    for (int i = 0; i < 20; i++) begin
      m = 16'($urandom);
      u = 8'($urandom);
      wr(8'h0C, m[7:0]);
      wr(8'h0D, m[15:8]);
      wr(8'h0E, u);
      idle();
      chk(unk, exp_unk(u));
      chk(pad, u[6]);
      for (int t = 0; t < 8; t++) begin
        @(posedge clk) pcp <= 3'(t);
        #1 chk(prio, m[t*2 +: 2]);
      end
    end
    wr(8'h06, 8'h00);
    wr(8'h07, 8'h03);
    rd(8'h07, 8'h03);
    // port 0 fast line, port 1 slow line, both flooded
    @(posedge clk) sin <= '{blk: 3'b011, fast_line_mode: 3'b001};
    f0 = -1;
    f1 = -1;
    repeat (300) begin
      prev = drop;
      @(posedge clk);
      #1;
      if (!prev[0] && drop[0] && f0 >= 0) chk(8'(cyc - f0), 8'h02);
      if (prev[0] && !drop[0]) begin
        if (f0 >= 0) chk(8'(cyc - f0), 8'h28);
        f0 = cyc;
      end
      if (prev[1] && !drop[1]) begin
        if (f1 >= 0) chk(8'(cyc - f1), 8'h64);
        f1 = cyc;
      end
    end
    @(posedge clk) sin <= '0;
    wr(8'h07, 8'h00);
    idle();
    repeat (3) @(posedge clk);
    #1 chk(drop, 8'h07);
    complete_run();
  end
endmodule
